// file: logic/ldmv_decode_map.vh
// constants for the load and move decode and timing block
// What this block does
// RULE1 - size bit: 0 byte, 1 word operation
// RULE2 - decode the four-bit general operand field
// RULE3 - decode the three-bit short destination field
// RULE4 - decode two-bit short source, one-bit address dest
// RULE5 - register zero byte store: selector, two cycles
// RULE6 - vector base load: split immediate, 8/4
// RULE7 - absolute extended load: 4 or 5 cycles
// RULE8 - displaced extended load: 4 or 5 cycles
// RULE9 - address pair extended load: 2-4 bytes, 4/5
// RULE10 - general immediate move: 2/3 cycles, word +byte
// RULE11 - quick immediate move: 1/2 cycles
// RULE12 - short byte immediate move: 1/2 cycles
// RULE13 - short immediate to address register: 2/1
// RULE14 - zero store byte move: 1/2 cycles
// RULE15 - general move: 2 cycles register, 3 memory
// RULE16 - move from stack offset: 2/3 cycles
// RULE17 - move to stack offset: 3/4 cycles
// RULE18 - unlisted operand codes are undefined
`ifndef LDMV_DECODE_MAP_VH
`define LDMV_DECODE_MAP_VH

// ==================================================================
// instruction form selector
`define LDMV_FORM_XLD_ABS    4'h0
`define LDMV_FORM_XLD_DSP    4'h1
`define LDMV_FORM_XLD_PAIR   4'h2
`define LDMV_FORM_VBASE      4'h3
`define LDMV_FORM_MOV_GIMM   4'h4
`define LDMV_FORM_MOV_QIMM   4'h5
`define LDMV_FORM_MOV_SBIMM  4'h6
`define LDMV_FORM_MOV_SAIMM  4'h7
`define LDMV_FORM_MOV_ZERO   4'h8
`define LDMV_FORM_MOV_GEN    4'h9
`define LDMV_FORM_MOV_S2A    4'hA
`define LDMV_FORM_MOV_R2M    4'hB
`define LDMV_FORM_MOV_M2R    4'hC
`define LDMV_FORM_MOV_FSP    4'hD
`define LDMV_FORM_MOV_TSP    4'hE

// ==================================================================
// operand mode codes
`define LDMV_MODE_DATA       3'h0
`define LDMV_MODE_ADDR       3'h1
`define LDMV_MODE_IND        3'h2
`define LDMV_MODE_DSP8_AREG  3'h3
`define LDMV_MODE_DSP8_BASE  3'h4
`define LDMV_MODE_DSP16_AREG 3'h5
`define LDMV_MODE_DSP16_SB   3'h6
`define LDMV_MODE_ABS16      3'h7

// base index for DSP8_BASE
`define LDMV_BASE_SB         2'h0
`define LDMV_BASE_FB         2'h1
`define LDMV_BASE_SP         2'h2

// far source index for extended loads
`define LDMV_FAR_ABS20       2'h0
`define LDMV_FAR_DSP20       2'h1
`define LDMV_FAR_PAIR        2'h2

// ==================================================================
// base byte counts (operand extension bytes are added)
`define LDMV_B_XLD_ABS       4'h5
`define LDMV_B_XLD_DSP       4'h5
`define LDMV_B_XLD_PAIR      4'h2
`define LDMV_B_VBASE         4'h8
`define LDMV_B_GIMM          4'h3
`define LDMV_B_QIMM          4'h2
`define LDMV_B_SBIMM         4'h2
`define LDMV_B_SAIMM         4'h2
`define LDMV_B_ZERO          4'h1
`define LDMV_B_GEN           4'h2
`define LDMV_B_SHORT         4'h1
`define LDMV_B_SP            4'h3

// ==================================================================
// cycle counts
`define LDMV_C_XLD_REG       3'h4
`define LDMV_C_XLD_MEM       3'h5
`define LDMV_C_VBASE         3'h4
`define LDMV_C_GIMM_REG      3'h2
`define LDMV_C_GIMM_MEM      3'h3
`define LDMV_C_QIMM_REG      3'h1
`define LDMV_C_QIMM_MEM      3'h2
`define LDMV_C_SBIMM_REG     3'h1
`define LDMV_C_SBIMM_MEM     3'h2
`define LDMV_C_SAIMM         3'h1
`define LDMV_C_ZERO_REG      3'h1
`define LDMV_C_ZERO_MEM      3'h2
`define LDMV_C_GEN_REG       3'h2
`define LDMV_C_GEN_MEM       3'h3
`define LDMV_C_SHORT_REG     3'h2
`define LDMV_C_SHORT_MEM     3'h3
`define LDMV_C_R2M           3'h2
`define LDMV_C_FSP_REG       3'h2
`define LDMV_C_FSP_MEM       3'h3
`define LDMV_C_TSP_REG       3'h3
`define LDMV_C_TSP_MEM       3'h4
`define LDMV_C_UNDEF         3'h1

`endif

// file: logic/ldmv_opnd_dec.v
// general four-bit operand field decoder
`timescale 1ns/10ps
`default_nettype none

module ldmv_opnd_dec (
  input  wire [3:0] code,
  output reg  [2:0] mode,
  output reg  [1:0] index,
  output reg  [1:0] ext,
  output reg        is_mem
);

`include "ldmv_decode_map.vh"

  // ================================================================
  // field decode
  always @* begin
    mode   = `LDMV_MODE_DATA;
    index  = 2'h0;
    ext    = 2'h0;
    is_mem = 1'b1;
    case (code[3:1]) // RULE2
      3'h0, 3'h1: begin
        mode   = `LDMV_MODE_DATA;
        index  = code[1:0];
        is_mem = 1'b0;
      end
      3'h2: begin
        mode   = `LDMV_MODE_ADDR;
        index  = {1'b0, code[0]};
        is_mem = 1'b0;
      end
      3'h3: begin
        mode  = `LDMV_MODE_IND;
        index = {1'b0, code[0]};
      end
      3'h4: begin
        mode  = `LDMV_MODE_DSP8_AREG;
        index = {1'b0, code[0]};
        ext   = 2'h1;
      end
      3'h5: begin
        // 1010 static base, 1011 frame base
        mode  = `LDMV_MODE_DSP8_BASE;
        index = code[0] ? `LDMV_BASE_FB : `LDMV_BASE_SB;
        ext   = 2'h1;
      end
      3'h6: begin
        mode  = `LDMV_MODE_DSP16_AREG;
        index = {1'b0, code[0]};
        ext   = 2'h2;
      end
      default: begin
        mode  = code[0] ? `LDMV_MODE_ABS16 : `LDMV_MODE_DSP16_SB;
        index = 2'h0;
        ext   = 2'h2;
      end
    endcase
  end

endmodule // ldmv_opnd_dec

`default_nettype wire

// file: logic/ldmv_decode.v
// load and move instruction decode with per-form cycle timing
`timescale 1ns/10ps
`default_nettype none

module ldmv_decode (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        start,
  input  wire [3:0]  form,
  input  wire        size_word,
  input  wire [3:0]  gen_src,
  input  wire [3:0]  gen_dst,
  input  wire [2:0]  short_dst3,
  input  wire [1:0]  short_fld2,
  input  wire        short_fld1,
  input  wire [3:0]  immediate_high_nibble,
  input  wire [15:0] immediate_low_half,
  output reg         busy,
  output reg         done,
  output reg         undefined_code,
  output reg         word_op,
  output reg  [3:0]  inst_bytes,
  output reg  [2:0]  inst_cycles,
  output reg         src_is_imm,
  output reg         src_is_far,
  output reg  [2:0]  src_mode,
  output reg  [1:0]  src_index,
  output reg  [2:0]  dst_mode,
  output reg  [1:0]  dst_index,
  output reg  [19:0] vector_base,
  output reg         vector_base_we
);

`include "ldmv_decode_map.vh"

  // ================================================================
  // states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  // ================================================================
  // helpers
  function [3:0] add_ext;
    input [3:0] base;
    input [1:0] ext;
    begin
      add_ext = base + {2'b00, ext};
    end
  endfunction

  // packs {undef, mode, index, ext}
  function [7:0] short3_dec;
    input [2:0] f;
    begin
      case (f) // RULE3
        3'h3:    short3_dec = {1'b0, `LDMV_MODE_DATA, 2'h1, 2'h0};
        3'h4:    short3_dec = {1'b0, `LDMV_MODE_DATA, 2'h0, 2'h0};
        3'h5:    short3_dec = {1'b0, `LDMV_MODE_DSP8_BASE, `LDMV_BASE_SB, 2'h1};
        3'h6:    short3_dec = {1'b0, `LDMV_MODE_DSP8_BASE, `LDMV_BASE_FB, 2'h1};
        3'h7:    short3_dec = {1'b0, `LDMV_MODE_ABS16, 2'h0, 2'h2};
        default: short3_dec = {1'b1, `LDMV_MODE_DATA, 2'h0, 2'h0}; // RULE18
      endcase
    end
  endfunction

  // packs {mode, index, ext}
  function [6:0] short2_dec;
    input [1:0] f;
    begin
      case (f) // RULE4
        2'h0:    short2_dec = {`LDMV_MODE_DATA, 2'h0, 2'h0};
        2'h1:    short2_dec = {`LDMV_MODE_DSP8_BASE, `LDMV_BASE_SB, 2'h1};
        2'h2:    short2_dec = {`LDMV_MODE_DSP8_BASE, `LDMV_BASE_FB, 2'h1};
        default: short2_dec = {`LDMV_MODE_ABS16, 2'h0, 2'h2};
      endcase
    end
  endfunction

  // ================================================================
  // operand field decoders
  wire [2:0] gs_mode;
  wire [1:0] gs_index;
  wire [1:0] gs_ext;
  wire       gs_mem;
  wire [2:0] gd_mode;
  wire [1:0] gd_index;
  wire [1:0] gd_ext;
  wire       gd_mem;

  ldmv_opnd_dec u_src_dec (
    .code   (gen_src),
    .mode   (gs_mode),
    .index  (gs_index),
    .ext    (gs_ext),
    .is_mem (gs_mem)
  );

  ldmv_opnd_dec u_dst_dec (
    .code   (gen_dst),
    .mode   (gd_mode),
    .index  (gd_index),
    .ext    (gd_ext),
    .is_mem (gd_mem)
  );

  wire [7:0] s3   = short3_dec(short_dst3);
  wire [6:0] s2   = short2_dec(short_fld2);
  wire       s3_u = s3[7];
  wire       s3_m = (s3[6:4] != `LDMV_MODE_DATA);
  wire       s2_m = (s2[6:4] != `LDMV_MODE_DATA);

  // ================================================================
  // per-form decode
  reg [3:0] d_bytes;
  reg [2:0] d_cyc;
  reg       d_word;
  reg       d_imm;
  reg       d_far;
  reg [2:0] d_smode;
  reg [1:0] d_sidx;
  reg [2:0] d_dmode;
  reg [1:0] d_didx;
  reg       d_undef;

  always @* begin
    d_bytes = 4'h0;
    d_cyc   = `LDMV_C_UNDEF;
    d_word  = size_word; // RULE1
    d_imm   = 1'b0;
    d_far   = 1'b0;
    d_smode = gs_mode;
    d_sidx  = gs_index;
    d_dmode = gd_mode;
    d_didx  = gd_index;
    d_undef = 1'b0;
    case (form)
      `LDMV_FORM_XLD_ABS: begin
        d_far   = 1'b1;
        d_sidx  = `LDMV_FAR_ABS20;
        d_bytes = add_ext(`LDMV_B_XLD_ABS, gd_ext); // RULE7
        d_cyc   = gd_mem ? `LDMV_C_XLD_MEM : `LDMV_C_XLD_REG; // RULE7
      end
      `LDMV_FORM_XLD_DSP: begin
        d_far   = 1'b1;
        d_sidx  = `LDMV_FAR_DSP20;
        d_bytes = add_ext(`LDMV_B_XLD_DSP, gd_ext); // RULE8
        d_cyc   = gd_mem ? `LDMV_C_XLD_MEM : `LDMV_C_XLD_REG; // RULE8
      end
      `LDMV_FORM_XLD_PAIR: begin
        d_far   = 1'b1;
        d_sidx  = `LDMV_FAR_PAIR;
        d_bytes = add_ext(`LDMV_B_XLD_PAIR, gd_ext); // RULE9
        d_cyc   = gd_mem ? `LDMV_C_XLD_MEM : `LDMV_C_XLD_REG; // RULE9
      end
      `LDMV_FORM_VBASE: begin
        // the 20-bit value is carried as two immediates, high nibble first
        d_imm   = 1'b1;
        d_word  = 1'b0;
        d_smode = `LDMV_MODE_DATA;
        d_sidx  = 2'h0;
        d_dmode = `LDMV_MODE_DATA;
        d_didx  = 2'h0;
        d_bytes = `LDMV_B_VBASE; // RULE6
        d_cyc   = `LDMV_C_VBASE; // RULE6
      end
      `LDMV_FORM_MOV_GIMM: begin
        d_imm   = 1'b1;
        d_bytes = add_ext(`LDMV_B_GIMM, gd_ext) + {3'h0, size_word}; // RULE10
        d_cyc   = gd_mem ? `LDMV_C_GIMM_MEM : `LDMV_C_GIMM_REG; // RULE10
      end
      `LDMV_FORM_MOV_QIMM: begin
        d_imm   = 1'b1;
        d_bytes = add_ext(`LDMV_B_QIMM, gd_ext); // RULE11
        d_cyc   = gd_mem ? `LDMV_C_QIMM_MEM : `LDMV_C_QIMM_REG; // RULE11
      end
      `LDMV_FORM_MOV_SBIMM: begin
        d_imm   = 1'b1;
        d_word  = 1'b0;
        d_dmode = s3[6:4];
        d_didx  = s3[3:2];
        d_undef = s3_u;
        d_bytes = add_ext(`LDMV_B_SBIMM, s3[1:0]); // RULE12
        d_cyc   = s3_m ? `LDMV_C_SBIMM_MEM : `LDMV_C_SBIMM_REG; // RULE12
      end
      `LDMV_FORM_MOV_SAIMM: begin
        d_imm   = 1'b1;
        d_dmode = `LDMV_MODE_ADDR;
        d_didx  = {1'b0, short_fld1};
        d_bytes = `LDMV_B_SAIMM + {3'h0, size_word}; // RULE13
        d_cyc   = `LDMV_C_SAIMM + {2'h0, size_word}; // RULE13
      end
      `LDMV_FORM_MOV_ZERO: begin
        d_imm   = 1'b1;
        d_word  = 1'b0;
        d_dmode = s3[6:4];
        d_didx  = s3[3:2];
        d_undef = s3_u;
        d_bytes = add_ext(`LDMV_B_ZERO, s3[1:0]); // RULE14
        d_cyc   = s3_m ? `LDMV_C_ZERO_MEM : `LDMV_C_ZERO_REG; // RULE14
      end
      `LDMV_FORM_MOV_GEN: begin
        d_bytes = add_ext(add_ext(`LDMV_B_GEN, gs_ext), gd_ext);
        d_cyc   = gs_mem ? `LDMV_C_GEN_MEM : `LDMV_C_GEN_REG; // RULE15
      end
      `LDMV_FORM_MOV_S2A: begin
        d_word  = 1'b0;
        d_smode = s2[6:4];
        d_sidx  = s2[3:2];
        d_dmode = `LDMV_MODE_ADDR;
        d_didx  = {1'b0, short_fld1}; // RULE4
        d_bytes = add_ext(`LDMV_B_SHORT, s2[1:0]);
        d_cyc   = s2_m ? `LDMV_C_SHORT_MEM : `LDMV_C_SHORT_REG;
      end
      `LDMV_FORM_MOV_R2M: begin
        d_word  = 1'b0;
        d_smode = `LDMV_MODE_DATA;
        d_sidx  = {1'b0, short_fld1}; // RULE5
        d_dmode = s2[6:4];
        d_didx  = s2[3:2];
        d_undef = (short_fld2 == 2'h0); // RULE18
        d_bytes = add_ext(`LDMV_B_SHORT, s2[1:0]);
        d_cyc   = `LDMV_C_R2M; // RULE5
      end
      `LDMV_FORM_MOV_M2R: begin
        d_word  = 1'b0;
        d_smode = s2[6:4];
        d_sidx  = s2[3:2];
        d_dmode = `LDMV_MODE_DATA;
        d_didx  = {1'b0, short_fld1};
        d_bytes = add_ext(`LDMV_B_SHORT, s2[1:0]);
        d_cyc   = s2_m ? `LDMV_C_SHORT_MEM : `LDMV_C_SHORT_REG;
      end
      `LDMV_FORM_MOV_FSP: begin
        d_smode = `LDMV_MODE_DSP8_BASE;
        d_sidx  = `LDMV_BASE_SP;
        d_bytes = add_ext(`LDMV_B_SP, gd_ext);
        d_cyc   = gd_mem ? `LDMV_C_FSP_MEM : `LDMV_C_FSP_REG; // RULE16
      end
      `LDMV_FORM_MOV_TSP: begin
        d_dmode = `LDMV_MODE_DSP8_BASE;
        d_didx  = `LDMV_BASE_SP;
        d_bytes = add_ext(`LDMV_B_SP, gs_ext);
        d_cyc   = gs_mem ? `LDMV_C_TSP_MEM : `LDMV_C_TSP_REG; // RULE17
      end
      default: begin
        d_undef = 1'b1; // RULE18
      end
    endcase
    // an undefined encoding spends a single cycle so the pipe never hangs
    if (d_undef) begin
      d_cyc = `LDMV_C_UNDEF; // RULE18
    end
  end

  // ================================================================
  // cycle sequencer
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] cnt_reg;
  reg [2:0] cnt_next;
  reg       vb_pend_reg;
  reg       vb_pend_next;
  wire      take = (state_reg == ST_IDLE) && start;
  wire      last = (state_reg == ST_RUN) && (cnt_reg == 3'h1);

  always @* begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    vb_pend_next = vb_pend_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next   = ST_RUN;
          cnt_next     = d_cyc;
          vb_pend_next = (form == `LDMV_FORM_VBASE);
        end
      end
      ST_RUN: begin
        if (cnt_reg == 3'h1) begin
          state_next   = ST_IDLE;
          cnt_next     = 3'h0;
          vb_pend_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      default: begin
        state_next   = ST_IDLE;
        cnt_next     = 3'h0;
        vb_pend_next = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 3'h0;
      vb_pend_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      vb_pend_reg <= vb_pend_next;
    end
  end

  // ================================================================
  // registered outputs
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy           <= 1'b0;
      done           <= 1'b0;
      vector_base_we <= 1'b0;
    end else begin
      busy           <= (state_next == ST_RUN);
      done           <= last;
      vector_base_we <= last && vb_pend_reg;
    end
  end

  // decode results hold from acceptance until the next accepted start
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      undefined_code <= 1'b0;
      word_op        <= 1'b0;
      inst_bytes     <= 4'h0;
      inst_cycles    <= 3'h0;
      src_is_imm     <= 1'b0;
      src_is_far     <= 1'b0;
      src_mode       <= 3'h0;
      src_index      <= 2'h0;
      dst_mode       <= 3'h0;
      dst_index      <= 2'h0;
      vector_base    <= 20'h00000;
    end else if (take) begin
      undefined_code <= d_undef;
      word_op        <= d_word;
      inst_bytes     <= d_bytes;
      inst_cycles    <= d_cyc;
      src_is_imm     <= d_imm;
      src_is_far     <= d_far;
      src_mode       <= d_smode;
      src_index      <= d_sidx;
      dst_mode       <= d_dmode;
      dst_index      <= d_didx;
      if (form == `LDMV_FORM_VBASE) begin
        vector_base <= {immediate_high_nibble, immediate_low_half}; // RULE6
      end
    end
  end

endmodule // ldmv_decode

`default_nettype wire

// file: testbench/ldmv_decode_chk_assertions.sv
// port checker for the load and move decode block
`timescale 1ns/10ps
`default_nettype none
// ====
// checker
module ldmv_decode_chk (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        start,
  input wire logic [3:0]  form,
  input wire logic        size_word,
  input wire logic [3:0]  gen_dst,
  input wire logic [3:0]  immediate_high_nibble,
  input wire logic [15:0] immediate_low_half,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        undefined_code,
  input wire logic        word_op,
  input wire logic [3:0]  inst_bytes,
  input wire logic [2:0]  inst_cycles,
  input wire logic [19:0] vector_base,
  input wire logic        vector_base_we
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire take = start && !busy;
  // busy length counter, compared against the reported count at done
  logic [3:0] busy_cnt_reg;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) busy_cnt_reg <= 4'h0;
    else if (busy) busy_cnt_reg <= busy_cnt_reg + 4'h1;
    else busy_cnt_reg <= 4'h0;
  end
  property p_busy_count; done |-> busy_cnt_reg == {1'b0, inst_cycles}; endproperty
  a_busy_count: assert property (p_busy_count) else $error("busy length differs from count");
  property p_done_pulse; done |=> !done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_refuse; busy |=> $stable(inst_bytes) && $stable(inst_cycles); endproperty
  a_refuse: assert property (p_refuse) else $error("decode changed while busy");
  property p_vbase;
    take && form == 4'h3 |=> vector_base[19:16] == $past(immediate_high_nibble)
      && vector_base[15:0] == $past(immediate_low_half);
  endproperty
  a_vbase: assert property (p_vbase) else $error("vector base value wrong");
  property p_vbase_time;
    take && form == 4'h3 |=> inst_bytes == 4'h8 && inst_cycles == 3'h4 ##4 done && vector_base_we;
  endproperty
  a_vbase_time: assert property (p_vbase_time) else $error("vector base load timing wrong");
  property p_we_done; vector_base_we |-> done; endproperty
  a_we_done: assert property (p_we_done) else $error("write strobe without done");
  property p_xld_reg; take && form <= 4'h2 && gen_dst < 4'h6 |=> inst_cycles == 3'h4 ##4 done; endproperty
  a_xld_reg: assert property (p_xld_reg) else $error("far load to register timing");
  property p_xld_mem; take && form <= 4'h2 && gen_dst > 4'h5 |=> inst_cycles == 3'h5 ##5 done; endproperty
  a_xld_mem: assert property (p_xld_mem) else $error("far load to memory timing");
  property p_word; take && form == 4'h9 |=> word_op == $past(size_word); endproperty
  a_word: assert property (p_word) else $error("size bit not followed");
  property p_undef; take && form == 4'hF |=> undefined_code && inst_cycles == 3'h1 ##1 done; endproperty
  a_undef: assert property (p_undef) else $error("undefined form not flagged");
  property p_qimm; take && form == 4'h5 && gen_dst < 4'h6 |=> inst_cycles == 3'h1 ##1 done; endproperty
  a_qimm: assert property (p_qimm) else $error("quick move timing wrong");
  c_vbase: cover property (take && form == 4'h3);
  c_refused: cover property (busy && start);
  c_gen_mem: cover property (take && form == 4'h9 && gen_dst > 4'h5);
endmodule // ldmv_decode_chk
bind ldmv_decode ldmv_decode_chk i_ldmv_decode_chk (.clk_sys(clk_sys), .resetn(resetn),
  .start(start), .form(form), .size_word(size_word), .gen_dst(gen_dst),
  .immediate_high_nibble(immediate_high_nibble), .immediate_low_half(immediate_low_half),
  .busy(busy), .done(done), .undefined_code(undefined_code), .word_op(word_op),
  .inst_bytes(inst_bytes), .inst_cycles(inst_cycles), .vector_base(vector_base),
  .vector_base_we(vector_base_we));
`default_nettype wire

// file: testbench/ldmv_fetch_model.sv
// fetch stream model presenting one instruction at a time
`timescale 1ns/10ps
`default_nettype none
// ====
// fetch model
module ldmv_fetch_model (
  input  wire logic        clk_sys,
  input  wire logic        busy,
  output var  logic        start,
  output wire logic [3:0]  form,
  output wire logic        size_word,
  output wire logic [3:0]  gen_src,
  output wire logic [3:0]  gen_dst,
  output wire logic [2:0]  short_dst3,
  output wire logic [1:0]  short_fld2,
  output wire logic        short_fld1,
  output wire logic [3:0]  immediate_high_nibble,
  output wire logic [15:0] immediate_low_half
);
  logic [38:0] fields;
  assign {form, size_word, gen_src, gen_dst, short_dst3, short_fld2, short_fld1,
          immediate_high_nibble, immediate_low_half} = fields;
  initial begin
    start = 1'b0;
    fields = 39'h0;
  end
  // hold asks for a second, refused request kept up while busy
  task send(input [38:0] f, input hold);
    integer n;
    begin
      @(negedge clk_sys);
      fields = f;
      start = 1'b1;
      n = 0;
      do begin @(negedge clk_sys); n++; end while (busy !== 1'b1 && n < 4);
      if (hold) begin
        fields[38:35] = 4'hF;
        fields[29:26] = ~fields[29:26];
        while (busy === 1'b1 && n < 12) begin @(negedge clk_sys); n++; end
      end
      start = 1'b0;
      // released fields never keep the last value
      fields = ~fields;
    end
  endtask
endmodule // ldmv_fetch_model
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the load and move decode block
`timescale 1ns/10ps
`default_nettype none
// ====
// bench
module testbench;
  logic        clk_sys, resetn;
  wire         start, size_word, short_fld1, busy, done, undefined_code, word_op;
  wire         src_is_imm, src_is_far, vector_base_we;
  wire [3:0]   form, gen_src, gen_dst, immediate_high_nibble, inst_bytes;
  wire [2:0]   short_dst3, inst_cycles, src_mode, dst_mode;
  wire [1:0]   short_fld2, src_index, dst_index;
  wire [15:0]  immediate_low_half;
  wire [19:0]  vector_base;
  integer      err_count = 0, compares = 0, cyc = 0, bcnt = 0, seen = 0, i, r;
  integer      seed = 32'hc5ca1a16;
  ldmv_decode i_ldmv_decode (.clk_sys(clk_sys), .resetn(resetn), .start(start), .form(form),
    .size_word(size_word), .gen_src(gen_src), .gen_dst(gen_dst), .short_dst3(short_dst3),
    .short_fld2(short_fld2), .short_fld1(short_fld1),
    .immediate_high_nibble(immediate_high_nibble), .immediate_low_half(immediate_low_half),
    .busy(busy), .done(done), .undefined_code(undefined_code), .word_op(word_op),
    .inst_bytes(inst_bytes), .inst_cycles(inst_cycles), .src_is_imm(src_is_imm),
    .src_is_far(src_is_far), .src_mode(src_mode), .src_index(src_index),
    .dst_mode(dst_mode), .dst_index(dst_index), .vector_base(vector_base),
    .vector_base_we(vector_base_we));
  ldmv_fetch_model i_ldmv_fetch_model (.clk_sys(clk_sys), .busy(busy), .start(start),
    .form(form), .size_word(size_word), .gen_src(gen_src), .gen_dst(gen_dst),
    .short_dst3(short_dst3), .short_fld2(short_fld2), .short_fld1(short_fld1),
    .immediate_high_nibble(immediate_high_nibble), .immediate_low_half(immediate_low_half));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (done === 1'b1) begin seen = bcnt; bcnt = 0; end
    else if (busy === 1'b1) bcnt = bcnt + 1;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin err_count++; tally_and_finish; end
  end
  task tally_and_finish;
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk_num(input [19:0] got, input [19:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_bit(input got, input exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function [3:0] ext(input [3:0] x);
    ext = x < 4'h8 ? 4'h0 : x < 4'hC ? 4'h1 : 4'h2;
  endfunction
  function [3:0] e3(input [2:0] x);
    e3 = x < 3'h5 ? 4'h0 : x < 3'h7 ? 4'h1 : 4'h2;
  endfunction
  function [3:0] e2(input [1:0] x);
    e2 = x == 2'h0 ? 4'h0 : x == 2'h3 ? 4'h2 : 4'h1;
  endfunction
  // short destination as the equivalent general operand code
  function [3:0] m3(input [2:0] x);
    m3 = x == 3'h3 ? 4'h1 : x == 3'h4 ? 4'h0 : x == 3'h5 ? 4'hA : x == 3'h6 ? 4'hB : 4'hF;
  endfunction
  // {mode, index}; index is not compared for the sixteen-bit forms
  function [4:0] gm(input [3:0] x);
    gm = x < 4'h4 ? {3'h0, x[1:0]} : x < 4'h6 ? {3'h1, 1'b0, x[0]} :
         x < 4'h8 ? {3'h2, 1'b0, x[0]} : x < 4'hA ? {3'h3, 1'b0, x[0]} :
         x < 4'hC ? {3'h4, 1'b0, x[0]} : x < 4'hE ? 5'h14 : x == 4'hE ? 5'h18 : 5'h1C;
  endfunction
  function [4:0] mq(input [2:0] m, input [1:0] ix, input [3:0] x);
    mq = {m, x < 4'hC ? ix : 2'h0};
  endfunction
  // {undefined, bytes, cycles}
  function [7:0] expect_of(input [3:0] f, input sw, input [3:0] s, input [3:0] d,
                           input [2:0] s3, input [1:0] s2);
    reg [3:0] b;
    reg [2:0] c;
    reg       u;
    begin
      u = 1'b0;
      b = 4'h0;
      c = 3'h1;
      case (f)
        4'h0, 4'h1: begin b = 4'h5 + ext(d); c = d > 4'h5 ? 3'h5 : 3'h4; end
        4'h2: begin b = 4'h2 + ext(d); c = d > 4'h5 ? 3'h5 : 3'h4; end
        4'h3: begin b = 4'h8; c = 3'h4; end
        4'h4: begin b = 4'h3 + ext(d) + sw; c = d > 4'h5 ? 3'h3 : 3'h2; end
        4'h5: begin b = 4'h2 + ext(d); c = d > 4'h5 ? 3'h2 : 3'h1; end
        4'h6, 4'h8: begin
          u = s3 < 3'h3;
          b = (f == 4'h6 ? 4'h2 : 4'h1) + e3(s3);
          c = s3 < 3'h5 ? 3'h1 : 3'h2;
        end
        4'h7: begin b = 4'h2 + sw; c = 3'h1 + sw; end
        4'h9: begin b = 4'h2 + ext(s) + ext(d); c = s > 4'h5 ? 3'h3 : 3'h2; end
        4'hA, 4'hC: begin b = 4'h1 + e2(s2); c = s2 == 2'h0 ? 3'h2 : 3'h3; end
        4'hB: begin u = s2 == 2'h0; b = 4'h1 + e2(s2); c = 3'h2; end
        4'hD: begin b = 4'h3 + ext(d); c = d > 4'h5 ? 3'h3 : 3'h2; end
        4'hE: begin b = 4'h3 + ext(s); c = s > 4'h5 ? 3'h4 : 3'h3; end
        default: u = 1'b1;
      endcase
      if (u) c = 3'h1;
      expect_of = {u, b, c};
    end
  endfunction
  task run(input [3:0] f, input sw, input [3:0] s, input [3:0] d, input [2:0] s3,
           input [1:0] s2, input s1, input [19:0] im, input hold);
    reg [7:0] e;
    integer   j;
    begin
      e = expect_of(f, sw, s, d, s3, s2);
      i_ldmv_fetch_model.send({f, sw, s, d, s3, s2, s1, im}, hold);
      #1;
      j = 0;
      while (done !== 1'b1 && j < 12) begin @(negedge clk_sys); #1; j++; end
      chk_bit(done, 1'b1);
      chk_bit(undefined_code, e[7]);
      chk_num(seen, e[2:0]);
      chk_num(inst_cycles, e[2:0]);
      if (!e[7]) chk_num(inst_bytes, e[6:3]);
      if (f != 4'h3 && f != 4'hF) chk_bit(word_op, sw && !(f inside {6, 8, 10, 11, 12}));
      chk_bit(vector_base_we, f == 4'h3);
      if (f == 4'h3) chk_num(vector_base, im);
      chk_bit(src_is_far, f < 4'h3);
      chk_bit(src_is_imm, f inside {3, 4, 5, 6, 7, 8});
      if (f == 4'h9) chk_num(mq(src_mode, src_index, s), gm(s));
      if (f == 4'h9) chk_num(mq(dst_mode, dst_index, d), gm(d));
      if ((f == 4'h6 || f == 4'h8) && s3 > 3'h2)
        chk_num(mq(dst_mode, dst_index, m3(s3)), gm(m3(s3)));
      if (f == 4'hA) chk_num({dst_mode, dst_index}, gm({3'h2, s1}));
      if (f == 4'hB) chk_num({src_mode, src_index}, gm({3'h0, s1}));
    end
  endtask
  initial begin
    resetn = 1'b0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_num({busy, done, inst_bytes, inst_cycles}, 20'h0);
    chk_num(vector_base, 20'h0);
    resetn = 1'b1;
    for (i = 0; i < 128; i++)
      run(i[3:0], i[6], {i[4], i[6:4]}, {i[6:4], i[5]}, i[6:4], i[5:4], i[4],
          {i[7:0], 12'h5A3}, 1'b0);
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      run(r[3:0], r[4], r[8:5], r[12:9], r[15:13], r[17:16], r[18], r[31:12], 1'b0);
    end
    run(4'h9, 1'b1, 4'hE, 4'h1, 3'h0, 2'h0, 1'b0, 20'h0, 1'b1);
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
